// file: rtl/tws_eeprom.sv
// two-wire serial memory slave: protocol engine, page latch, write timer
// assumes scl_clk is the master's serial clock, sda pins resolved outside
`timescale 1ns/100ps
module tws_eeprom #(
  parameter int VARIANT = tws_pkg::VAR_8K,
  parameter int WR_CYCLES = tws_pkg::WR_CYCLES
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // chip-select straps
  input wire logic chip_select_pin_high,
  input wire logic chip_select_pin_mid
);
  // ----------------------------------------------------------------
  // sizing
  // ----------------------------------------------------------------
  localparam int ABITS = (VARIANT == tws_pkg::VAR_4K) ? tws_pkg::ABITS_4K :
                         (VARIANT == tws_pkg::VAR_8K) ? tws_pkg::ABITS_8K : tws_pkg::ABITS_MOD;
  localparam int DEPTH = 1 << ABITS;
  localparam int WRW = $clog2(WR_CYCLES + 1);

  // refuse settings the logic cannot serve
  if (VARIANT < 0 || VARIANT > 2 || WR_CYCLES < 1) begin : g_bad_param
    $error("tws_eeprom: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // link domain: sample data on rising serial clock
  // ----------------------------------------------------------------
  logic lk_bit;
  logic lk_tgl;

  // bit value held stable with a toggle marking each new sample
  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      lk_bit <= 1'b0;
      lk_tgl <= 1'b0;
    end
    else
    begin
      lk_bit <= sda_in;
      lk_tgl <= ~lk_tgl;
    end
  end

  // ----------------------------------------------------------------
  // synchronisers into the core domain
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic tg_s1, tg_s2, tg_s3;
  logic csh_s1, csh_s2, csm_s1, csm_s2;

  // two flops per line, third flop for edge history on clock, data and toggle only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {tg_s1, tg_s2, tg_s3} <= 3'h0;
      {csh_s1, csh_s2, csm_s1, csm_s2} <= 4'h0;
    end
    else
    begin
      {scl_s1, scl_s2, scl_s3} <= {scl_clk, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
      {tg_s1, tg_s2, tg_s3} <= {lk_tgl, tg_s1, tg_s2};
      {csh_s1, csh_s2, csm_s1, csm_s2} <= {chip_select_pin_high, csh_s1, chip_select_pin_mid, csm_s1};
    end
  end

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  tws_pkg::tws_state_e st;
  logic [3:0] cnt;
  logic ack;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [1:0] pg;
  logic [ABITS-1:0] addr;
  logic [tws_pkg::PAGE_BYTES-1:0] pmask;
  logic [7:0] pbuf [tws_pkg::PAGE_BYTES];
  logic [7:0] mem [DEPTH];
  logic busy;
  logic [WRW-1:0] wr_cnt;

  // device address check per variant
  function automatic logic dev_match(input logic [7:0] b, input logic hi, input logic mid);
    logic ok;
    ok = (b[7:4] == tws_pkg::DEV_TYPE);
    if (VARIANT == tws_pkg::VAR_4K)
      ok = ok && b[tws_pkg::DEV_CS_HI_BIT] == hi && b[tws_pkg::DEV_CS_MID_BIT] == mid;
    else if (VARIANT == tws_pkg::VAR_8K)
      ok = ok && b[tws_pkg::DEV_CS_HI_BIT] == hi;
    // RQ8: module variant wants zeros after the type
    else
      ok = ok && b[3:1] == 3'h0;
    return ok;
  endfunction : dev_match

  // ----------------------------------------------------------------
  // event decoding
  // ----------------------------------------------------------------
  // RQ1: start and stop from data edges under high clock
  wire start_ev = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  wire stop_ev = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  wire fall_ev = scl_s3 && !scl_s2;
  wire rise_ev = tg_s2 ^ tg_s3;
  wire in_bit = lk_bit;
  wire [7:0] byte_in = {sh[6:0], in_bit};
  wire active = (st != tws_pkg::ST_IDLE);
  // RQ2: eight bit slots then one acknowledge slot
  wire byte_done = rise_ev && active && cnt == tws_pkg::LAST_BIT;
  wire slot_rise = rise_ev && active && cnt == tws_pkg::ACK_SLOT;
  // RQ5: type pattern and strap compare
  wire dev_ok = dev_match(byte_in, csh_s2, csm_s2);
  // RQ16: polled address refused while the write runs
  wire dev_take = dev_ok && !busy;
  // RQ9: eighth bit picks the direction
  wire dev_read = byte_in[tws_pkg::DEV_RW_BIT];
  // RQ6: 4K keeps one page bit, RQ7: 8K keeps two
  wire [9:0] full_addr = {pg, byte_in};
  wire [ABITS-1:0] load_addr = full_addr[ABITS-1:0];
  // RQ18: reads wrap over the whole array
  wire [ABITS-1:0] rd_next = ABITS'(addr + 1'b1);
  // RQ15: writes step inside the page only
  wire [3:0] wr_low = addr[3:0] + 4'h1;
  wire [ABITS-1:0] wr_next = {addr[ABITS-1:tws_pkg::PAGE_BITS], wr_low};
  wire wr_take = byte_done && st == tws_pkg::ST_WDATA;
  // RQ14: programming starts only on the closing stop
  wire commit = stop_ev && st == tws_pkg::ST_WDATA && |pmask;
  wire drive_low = (cnt == tws_pkg::ACK_SLOT && ack) ||
                   (st == tws_pkg::ST_RDATA && !cnt[3] && !tx[7]);

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  // RQ4: every start waits for a device address word
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st <= tws_pkg::ST_IDLE;
      cnt <= 4'h0;
      ack <= 1'b0;
      sh <= 8'h00;
      tx <= 8'h00;
      pg <= 2'h0;
      addr <= '0;
      pmask <= '0;
    end
    else if (start_ev)
    begin
      st <= tws_pkg::ST_DEV;
      cnt <= 4'h0;
      ack <= 1'b0;
      pmask <= '0;
    end
    else if (stop_ev)
    begin
      st <= tws_pkg::ST_IDLE;
      cnt <= 4'h0;
      ack <= 1'b0;
      pmask <= '0;
    end
    else if (slot_rise)
    begin
      cnt <= 4'h0;
      ack <= 1'b0;
      // RQ21: master ack fetches next byte, no ack ends
      if (!ack && st == tws_pkg::ST_RDATA && in_bit)
        st <= tws_pkg::ST_IDLE;
      else if (!ack && st == tws_pkg::ST_RDATA)
        tx <= mem[addr];
    end
    else if (rise_ev && active)
    begin
      cnt <= cnt + 4'h1;
      sh <= byte_in;
      if (st == tws_pkg::ST_RDATA)
        tx <= {tx[6:0], 1'b0};
      if (cnt == tws_pkg::LAST_BIT)
      begin
        case (st)
          tws_pkg::ST_DEV:
          begin
            // RQ10: ack on match, standby on mismatch
            ack <= dev_take;
            pg <= byte_in[2:1];
            if (!dev_take)
              st <= tws_pkg::ST_IDLE;
            else if (dev_read)
              st <= tws_pkg::ST_RDATA;
            else
              st <= tws_pkg::ST_WADDR;
            // RQ19: current read starts at the counter
            tx <= mem[addr];
          end
          tws_pkg::ST_WADDR:
          begin
            // RQ11: word address loads the counter
            ack <= 1'b1;
            addr <= load_addr;
            st <= tws_pkg::ST_WDATA;
          end
          tws_pkg::ST_WDATA:
          begin
            // RQ13: every data byte acked
            ack <= 1'b1;
            pmask[addr[3:0]] <= 1'b1;
            addr <= wr_next;
          end
          tws_pkg::ST_RDATA:
          begin
            // RQ17: counter ends one past the byte sent
            addr <= rd_next;
          end
          default:
          begin
            ack <= 1'b0;
          end
        endcase
      end
    end
  end

  // page latch, later bytes overwrite on wrap
  always_ff @(posedge core_clk)
  begin
    if (wr_take)
      pbuf[addr[3:0]] <= byte_in;
  end

  // RQ3: array programmed at the valid stop
  always_ff @(posedge core_clk)
  begin
    if (commit)
      for (int i = 0; i < tws_pkg::PAGE_BYTES; i++)
        if (pmask[i])
          mem[{addr[ABITS-1:tws_pkg::PAGE_BITS], 4'(i)}] <= pbuf[i];
  end

  // ----------------------------------------------------------------
  // self-timed write cycle
  // ----------------------------------------------------------------
  // RQ12: busy from stop until the count runs out
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      wr_cnt <= '0;
    end
    else if (commit)
    begin
      busy <= 1'b1;
      wr_cnt <= WRW'(WR_CYCLES);
    end
    else if (busy)
    begin
      wr_cnt <= wr_cnt - 1'b1;
      busy <= (wr_cnt != WRW'(1));
    end
  end

  // ----------------------------------------------------------------
  // data line driver
  // ----------------------------------------------------------------
  // RQ22: pull low for zeros only, change on falling clock
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      if (start_ev || stop_ev)
        sda_oe_n <= 1'b1;
      else if (fall_ev)
        sda_oe_n <= !drive_low;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_dev_byte;
    byte_done && st == tws_pkg::ST_DEV;
  endsequence
  sequence s_write_byte;
    byte_done && st == tws_pkg::ST_WDATA;
  endsequence

  a_start_to_dev: assert property (start_ev |=> st == tws_pkg::ST_DEV && cnt == 4'h0) // RQ4
    else $error("start did not enter address phase");
  a_stop_to_idle: assert property (stop_ev |=> st == tws_pkg::ST_IDLE && sda_oe_n) // RQ1
    else $error("stop did not return to idle");
  a_poll_no_ack: assert property (s_dev_byte ##0 busy |=> !ack ##1 !ack) // RQ16
    else $error("acknowledged while write cycle runs");
  a_match_ack: assert property (s_dev_byte ##0 dev_take |=> ack && cnt == tws_pkg::ACK_SLOT) // RQ10
    else $error("matching address not acknowledged");
  a_mismatch_idle: assert property (s_dev_byte ##0 !dev_ok |=> st == tws_pkg::ST_IDLE && !ack) // RQ5
    else $error("mismatched address not refused");
  a_read_select: assert property (s_dev_byte ##0 dev_take && dev_read |=> st == tws_pkg::ST_RDATA) // RQ9
    else $error("read bit did not select read");
  a_page_wrap: assert property (s_write_byte |=> addr[3:0] == $past(wr_low) // RQ15
    && addr[ABITS-1:4] == $past(addr[ABITS-1:4]))
    else $error("write address left its page");
  a_read_step: assert property (byte_done && st == tws_pkg::ST_RDATA |=> addr == $past(rd_next)) // RQ17
    else $error("read counter not advanced");
  a_write_busy: assert property (commit |=> busy && wr_cnt == WRW'(WR_CYCLES)) // RQ12
    else $error("write cycle not started at stop");
  a_busy_end: assert property ($fell(busy) |-> $past(wr_cnt) == WRW'(1)) // RQ3
    else $error("write cycle ended early");
  a_ack_drive: assert property (fall_ev && ack && cnt == tws_pkg::ACK_SLOT && !start_ev && !stop_ev // RQ2
    |=> !sda_oe_n)
    else $error("acknowledge not driven low");
endmodule : tws_eeprom

// file: include/tws_pkg.sv
// constants, state type and timing for the two-wire memory slave
// assumes a 125 MHz core clock and a master that drives the serial clock
//
// Overview of operation
// RQ1: sda fall/rise while scl high: start/stop
// RQ2: eight-bit words, receiver acks with zero
// RQ3: write time runs from stop to done
// RQ4: device address word first after start
// RQ5: accept only the 1010 type pattern
// RQ6: 4K compares two pins, one page bit
// RQ7: 8K compares one pin, two page bits
// RQ8: module variant needs three zero bits
// RQ9: eighth bit high reads, low writes
// RQ10: ack on match, else back to standby
// RQ11: byte write: word address, data, stop
// RQ12: no ack while self-timed write runs
// RQ13: up to sixteen bytes per page, all acked
// RQ14: master ends page write with stop
// RQ15: writes step low four bits, page wraps
// RQ16: address poll acked only when not busy
// RQ17: counter keeps last address plus one
// RQ18: reads wrap from top to zero
// RQ19: current read sends byte at counter
// RQ20: random read uses a dummy write first
// RQ21: master ack steps to the next byte
// RQ22: open-drain data line, pull low only
package tws_pkg;
  // protocol engine states
  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_RDATA} tws_state_e;
  // device address word layout
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int DEV_RW_BIT = 0;
  localparam int DEV_CS_HI_BIT = 3;
  localparam int DEV_CS_MID_BIT = 2;
  // bit slot counter values
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // page layout
  localparam int PAGE_BITS = 4;
  localparam int PAGE_BYTES = 16;
  // memory variants and their word address widths
  localparam int VAR_4K = 0;
  localparam int VAR_8K = 1;
  localparam int VAR_MOD = 2;
  localparam int ABITS_4K = 9;
  localparam int ABITS_8K = 10;
  localparam int ABITS_MOD = 8;
  // self-timed write cycle
  localparam int CLK_MHZ = 125;
  localparam int WR_TIME_MS = 5;
  localparam int WR_CYCLES = WR_TIME_MS * CLK_MHZ * 1000;
endpackage : tws_pkg

// file: sim/tws_master.sv
// bus master model: makes the serial clock and drives the data wire
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/100ps
module tws_master (
  // serial link
  output logic scl_clk,
  output logic sda_m,
  input wire logic sda
);
  logic tick;
  // link timebase, 32 ns period; serial clock moves only in frames
  initial
  begin
    tick = 1'b0;
    scl_clk = 1'b1;
    sda_m = 1'b1;
    #5;
    forever #16 tick = ~tick;
  end
  task automatic t(input int n);
    repeat (n) @(posedge tick);
  endtask : t
  // start: data falls while clock high
  task automatic start();
    sda_m = 1'b1;
    t(1);
    scl_clk = 1'b1;
    t(1);
    sda_m = 1'b0;
    t(1);
    scl_clk = 1'b0;
  endtask : start
  // stop: data rises while clock high
  task automatic stop();
    t(1);
    sda_m = 1'b0;
    t(1);
    scl_clk = 1'b1;
    t(1);
    sda_m = 1'b1;
    t(2);
  endtask : stop
  // one clock: data set in low phase, sampled at rise
  task automatic bit_x(input logic b, output logic r);
    t(1);
    sda_m = b;
    t(1);
    scl_clk = 1'b1;
    r = sda;
    t(2);
    scl_clk = 1'b0;
  endtask : bit_x
  // eight bits first, then released ack slot
  task automatic wbyte(input logic [7:0] d, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], a);
    bit_x(1'b1, a);
  endtask : wbyte
  // master ack (0) asks for more, 1 ends the read
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(mack, r);
  endtask : rbyte
endmodule : tws_master

// file: sim/tb.sv
// self-checking bench for the two-wire memory slave, 8K variant,
// with a 4K and a module variant sharing the data wire
// assumes 8K straps high=1, mid=0, 4K straps high=0, mid=1, short write cycle
`timescale 1ns/100ps
module tb;
  logic core_clk, rst, cs_hi, cs_mid, scl_clk, sda_m, sda_out, sda_oe_n, a;
  logic cs4_hi, cs4_mid, sda_out4, sda_oe4_n, sda_outm, sda_oem_n;
  logic [7:0] d, e;
  int n, i;
  int err_total = 0;
  int cmp_count = 0;
  typedef struct {logic [7:0] dev; logic ack;} tws_row_s;
  // a0 is taken by the module part, a4/a6 by the 4K part, a2 by none
  tws_row_s rows [9] = '{'{8'ha8, 1'b0}, '{8'hae, 1'b0}, '{8'ha0, 1'b0},
    '{8'hb8, 1'b1}, '{8'he8, 1'b1}, '{8'h28, 1'b1}, '{8'ha4, 1'b0}, '{8'ha6, 1'b0}, '{8'ha2, 1'b1}};
  // pulled-up wire, low when any side pulls
  wire sda = sda_m & (sda_oe_n | sda_out) & (sda_oe4_n | sda_out4) & (sda_oem_n | sda_outm);
  tws_eeprom #(.VARIANT(tws_pkg::VAR_4K), .WR_CYCLES(200)) dut_4k (.core_clk(core_clk), .rst(rst),
    .scl_clk(scl_clk), .sda_in(sda), .sda_out(sda_out4), .sda_oe_n(sda_oe4_n),
    .chip_select_pin_high(cs4_hi), .chip_select_pin_mid(cs4_mid));
  tws_eeprom #(.VARIANT(tws_pkg::VAR_MOD), .WR_CYCLES(200)) dut_mod (.core_clk(core_clk), .rst(rst),
    .scl_clk(scl_clk), .sda_in(sda), .sda_out(sda_outm), .sda_oe_n(sda_oem_n),
    .chip_select_pin_high(cs_hi), .chip_select_pin_mid(cs_mid));
  tws_eeprom #(.WR_CYCLES(200)) dut (.core_clk(core_clk), .rst(rst), .scl_clk(scl_clk),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .chip_select_pin_high(cs_hi), .chip_select_pin_mid(cs_mid));
  tws_master m (.scl_clk(scl_clk), .sda_m(sda_m), .sda(sda));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic chk_bit(input string nm, input logic x, input logic g);
    cmp_count++;
    if (g !== x)
    begin
      err_total++;
      $display("unexpected %s exp %b got %b", nm, x, g);
    end
  endtask : chk_bit
  task automatic chk_byte(input string nm, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, x, g);
    end
  endtask : chk_byte
  // retry a write address until the write cycle ends, bounded
  task automatic poll(output int k);
    logic q;
    k = 0;
    q = 1'b1;
    while (q !== 1'b0 && k < 20)
    begin
      m.start();
      m.wbyte(8'ha8, q);
      m.stop();
      k++;
    end
    if (q !== 1'b0)
    begin
      err_total++;
      final_report();
    end
  endtask : poll
  // write n bytes counting up from first, then stop
  task automatic wr(input logic [7:0] dev, input logic [7:0] adr, input logic [7:0] first, input int k);
    logic q;
    m.start();
    m.wbyte(dev, q);
    chk_bit("dev ack", 1'b0, q);
    m.wbyte(adr, q);
    chk_bit("addr ack", 1'b0, q);
    for (int j = 0; j < k; j++)
    begin
      m.wbyte(first + 8'(j), q);
      chk_bit("data ack", 1'b0, q);
    end
    m.stop();
  endtask : wr
  // dummy write of the address, repeated start, read address
  task automatic rd_at(input logic [7:0] dev, input logic [7:0] adr);
    logic q;
    m.start();
    m.wbyte(dev, q);
    m.wbyte(adr, q);
    m.start();
    m.wbyte(dev | 8'h01, q);
    chk_bit("read ack", 1'b0, q);
  endtask : rd_at
  initial
  begin
    #400000;
    err_total++;
    final_report();
  end
  initial
  begin
    rst = 1'b1;
    cs_hi = 1'b1;
    cs_mid = 1'b0;
    cs4_hi = 1'b0;
    cs4_mid = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk_bit("oe idle", 1'b1, sda_oe_n);
    chk_bit("sda_out", 1'b0, sda_out);
    foreach (rows[r])
    begin
      m.start();
      m.wbyte(rows[r].dev, a);
      chk_bit("dev ack", rows[r].ack, a);
      m.stop();
    end
    // page 1, start at 0x1e, 18 bytes wrap inside the page
    wr(8'haa, 8'h1e, 8'h40, 18);
    poll(n);
    chk_bit("busy poll", 1'b1, n > 1);
    rd_at(8'haa, 8'h10);
    for (i = 0; i < 15; i++)
    begin
      n = (i + 2) & 15;
      e = 8'h40 + 8'(n < 2 ? n + 16 : n);
      m.rbyte(i == 14, d);
      chk_byte("page byte", e, d);
    end
    m.stop();
    m.start();
    m.wbyte(8'hab, a);
    chk_bit("current ack", 1'b0, a);
    m.rbyte(1'b1, d);
    m.stop();
    chk_byte("current read", 8'h51, d);
    wr(8'hae, 8'hff, 8'h5a, 1);
    poll(n);
    wr(8'ha8, 8'h00, 8'ha5, 1);
    poll(n);
    rd_at(8'hae, 8'hff);
    m.rbyte(1'b0, d);
    chk_byte("top byte", 8'h5a, d);
    m.rbyte(1'b1, d);
    chk_byte("wrap byte", 8'ha5, d);
    m.stop();
    // mid-run reset: line released, counter back to zero
    @(negedge core_clk);
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    chk_bit("oe after reset", 1'b1, sda_oe_n);
    m.start();
    m.wbyte(8'hab, a);
    chk_bit("reset read ack", 1'b0, a);
    m.rbyte(1'b1, d);
    m.stop();
    chk_byte("reset counter", 8'ha5, d);
    final_report();
  end
endmodule : tb
